// ===== inc/pci_cfg_defines.svh
`ifndef PCI_CFG_DEFINES_SVH
`define PCI_CFG_DEFINES_SVH

// configuration-space byte offsets
`define CFG_CMD_STS_OFF 8'h04
`define CFG_PCIX_CAP_OFF 8'he4
`define CFG_PCIX_STS_OFF 8'he8

// pci-x capability header
`define PCIX_CAP_ID 8'h07
`define PCIX_NEXT_PTR 8'hf0
`define PCIX_NEXT_NONE 8'h00

// command register bits
`define CMD_INT_DIS 10
`define CMD_RESET 11'h000

// status register bits
`define STS_INT 3
`define STS_CAP_LIST 4
`define STS_M66 5
`define STS_UDF 6
`define STS_FB2B 7
`define STS_DPR 8
`define STS_DEVSEL_LO 9
`define STS_DEVSEL_HI 10
`define STS_DEVSEL_MEDIUM 2'b01

// pci-x command and status words
`define PCIX_CMD_RESET 7'h02
`define PCIX_STS_SCD 18
`define PCIX_DEV_NUM_RST 5'h1f
`define PCIX_BUS_NUM_RST 8'hff
`define PCIX_FUNC_NUM_RST 3'h0

`endif

// ===== inc/pci_cfg_pkg.sv
package pci_cfg_pkg;

   // packed so that bit n of the struct is command bit n
   typedef struct packed {
      logic int_disable;
      logic fast_b2b;
      logic serr_en;
      logic wait_cycle;
      logic parity_resp;
      logic palette_snoop;
      logic mwi_en;
      logic special_cycle;
      logic master_en;
      logic mem_en;
      logic io_en;
   } cmd_bits_t;

   // error flags, one bit per sticky status flag
   typedef struct packed {
      logic det_parity;
      logic sig_serr;
      logic rcv_master_abort;
      logic rcv_target_abort;
      logic sig_target_abort;
      logic data_parity;
   } err_events_t;

   // packed so that bit n of the struct is pci-x command bit n
   typedef struct packed {
      logic [2:0] max_split;
      logic [1:0] max_read;
      logic relaxed_order;
      logic dpe_recovery;
   } pcix_cmd_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } cfg_req_t;

   typedef struct packed {
      cmd_bits_t cmd;
      pcix_cmd_t pxcmd;
      pcix_cmd_t pxctl;
      logic scd;
      logic dpr_seen;
      logic [31:0] rdata;
      logic rvalid;
      logic inta_oe;
      logic link_int;
      logic serr_oe;
      logic split_ok;
   } regs_state_t;

   typedef struct packed {
      err_events_t flags;
   } flags_state_t;

endpackage

// ===== hw/err_flag_bank.sv
`include "pci_cfg_defines.svh"

module err_flag_bank (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire pci_cfg_pkg::err_events_t set_i,
   input wire pci_cfg_pkg::err_events_t clr_i,
   output pci_cfg_pkg::err_events_t flags_o
);

   pci_cfg_pkg::flags_state_t st_ff;
   pci_cfg_pkg::flags_state_t nxt_st;

   // a set in the clearing cycle wins so no event is lost
   always_comb begin
      nxt_st = st_ff;
      for (int i = 0; i < $bits(pci_cfg_pkg::err_events_t); i++) begin
         nxt_st.flags[i] = set_i[i] | (st_ff.flags[i] & ~clr_i[i]); // R15
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_ff <= '0; // R09
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign flags_o = st_ff.flags;

   default clocking @(posedge ref_clk_i); endclocking

   property p_flag_reset;
      disable iff (1'b0) srst_i |=> (flags_o == '0);
   endproperty
   a_flag_reset: assert property (p_flag_reset) else $error("error flag not zero after reset"); // R09

   property p_w1c;
      disable iff (srst_i) (clr_i.det_parity && !set_i.det_parity) |=> !flags_o.det_parity;
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear flag"); // R15

   property p_set_wins;
      disable iff (srst_i)
         set_i.sig_serr |=> flags_o.sig_serr ##1 (flags_o.sig_serr || $past(clr_i.sig_serr));
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("flag lost or not sticky"); // R15

endmodule

// ===== hw/pci_config_cmd_status_regs.sv
// What this block does
// R01: ten command enable bits, all reset zero
// R02: pci-x split completions ignore mastering enable
// R03: bit 10 interrupt disable on some variants
// R04: status bit 3 pending; pin gated by disable
// R05: status bit 4 capability list reads one
// R06: 66 MHz bit one, UDF bit zero
// R07: fast back-to-back capable zero in pci-x
// R08: devsel timing reads medium encoding 01b
// R09: six error flags reset to zero
// R10: pci-x registers act only in pci-x mode
// R11: pci-x header at E4h, status at E8h
// R12: capability id reads seven, read-only
// R13: next pointer F0, zero if msi hidden; the code zeroes it only when msi is hidden in conventional mode
// R14: parity flag raises system error when unrecoverable
// R15: write one clears error flag, zero keeps
// R16: reserved bits read zero, ignore writes
`include "pci_cfg_defines.svh"

module pci_config_cmd_status_regs #(
   parameter bit INT_DISABLE_IMPL = 1'b1,
   parameter bit FB2B_CAPABLE = 1'b0,
   parameter bit DEV_64BIT = 1'b1,
   parameter bit CAP_133MHZ = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire pci_cfg_pkg::cfg_req_t cfg_req_i,
   input wire logic pcix_mode_i,
   input wire logic msi_disabled_i,
   input wire logic int_pending_i,
   input wire pci_cfg_pkg::err_events_t err_evt_i,
   input wire logic serr_req_i,
   input wire logic split_discard_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   output pci_cfg_pkg::cmd_bits_t cmd_o,
   output pci_cfg_pkg::pcix_cmd_t pcix_ctl_o,
   output logic split_ok_o,
   output logic inta_oe_o,
   output logic link_int_o,
   output logic serr_oe_o
);

   localparam pci_cfg_pkg::regs_state_t RESET_ST = '{
      cmd: `CMD_RESET,
      pxcmd: `PCIX_CMD_RESET,
      pxctl: '0,
      scd: 1'b0,
      dpr_seen: 1'b0,
      rdata: 32'h0000_0000,
      rvalid: 1'b0,
      inta_oe: 1'b0,
      link_int: 1'b0,
      serr_oe: 1'b0,
      split_ok: 1'b0
   };

   pci_cfg_pkg::regs_state_t st_ff;
   pci_cfg_pkg::regs_state_t nxt_st;
   pci_cfg_pkg::err_events_t flags;
   pci_cfg_pkg::err_events_t flag_set;
   pci_cfg_pkg::err_events_t flag_clr;
   logic [15:0] status_word;
   logic [31:0] pcix_status;
   logic [7:0] next_ptr;
   logic recovery_on;
   logic serr_now;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr[7:2] == off[7:2]);
   endfunction

   err_flag_bank u_flags (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .set_i(flag_set),
      .clr_i(flag_clr),
      .flags_o(flags)
   );

   // recovery control only matters while the bus runs pci-x
   assign recovery_on = pcix_mode_i & st_ff.pxcmd.dpe_recovery; // R10

   always_comb begin
      serr_now = serr_req_i & st_ff.cmd.serr_en;
      // unrecoverable parity: new data-parity flag drives system error
      if (flags.data_parity && !st_ff.dpr_seen && !recovery_on && st_ff.cmd.serr_en) begin
         serr_now = 1'b1; // R14
      end
   end

   always_comb begin
      flag_set = err_evt_i;
      flag_set.sig_serr = err_evt_i.sig_serr | serr_now;
      flag_clr = '0;
      if (cfg_req_i.wr && hit(cfg_req_i.addr, `CFG_CMD_STS_OFF)) begin
         // status bit 8 sits in byte lane 3, so only that lane may clear it
         if (cfg_req_i.be[3]) begin
            flag_clr.data_parity = cfg_req_i.wdata[16 + `STS_DPR]; // R15
         end
         if (cfg_req_i.be[3]) begin
            flag_clr.sig_target_abort = cfg_req_i.wdata[27];
            flag_clr.rcv_target_abort = cfg_req_i.wdata[28];
            flag_clr.rcv_master_abort = cfg_req_i.wdata[29];
            flag_clr.sig_serr = cfg_req_i.wdata[30];
            flag_clr.det_parity = cfg_req_i.wdata[31]; // R15
         end
      end
   end

   always_comb begin
      status_word = 16'h0000; // R16
      status_word[`STS_INT] = int_pending_i; // R04
      status_word[`STS_CAP_LIST] = 1'b1; // R05
      status_word[`STS_M66] = 1'b1; // R06
      status_word[`STS_UDF] = 1'b0; // R06
      status_word[`STS_FB2B] = FB2B_CAPABLE & ~pcix_mode_i; // R07
      status_word[`STS_DPR] = flags.data_parity; // R09
      status_word[`STS_DEVSEL_HI:`STS_DEVSEL_LO] = `STS_DEVSEL_MEDIUM; // R08
      status_word[15:11] = {flags.det_parity, flags.sig_serr, flags.rcv_master_abort,
                            flags.rcv_target_abort, flags.sig_target_abort}; // R09
   end

   // msi entry drops out of the list only in conventional mode
   assign next_ptr = (!pcix_mode_i && msi_disabled_i) ? `PCIX_NEXT_NONE
                                                      : `PCIX_NEXT_PTR; // R13

   always_comb begin
      pcix_status = 32'h0000_0000;
      pcix_status[2:0] = `PCIX_FUNC_NUM_RST;
      pcix_status[7:3] = `PCIX_DEV_NUM_RST;
      pcix_status[15:8] = `PCIX_BUS_NUM_RST;
      pcix_status[16] = DEV_64BIT;
      pcix_status[17] = CAP_133MHZ;
      pcix_status[`PCIX_STS_SCD] = st_ff.scd;
   end

   always_comb begin
      nxt_st = st_ff;
      nxt_st.rvalid = cfg_req_i.rd;
      nxt_st.dpr_seen = flags.data_parity;
      nxt_st.serr_oe = serr_now;
      // split-discard event wins over a clearing write
      nxt_st.scd = split_discard_i | st_ff.scd;
      if (cfg_req_i.rd) begin
         if (hit(cfg_req_i.addr, `CFG_CMD_STS_OFF)) begin
            nxt_st.rdata = {status_word, 5'h00, st_ff.cmd}; // R16
         end else if (hit(cfg_req_i.addr, `CFG_PCIX_CAP_OFF)) begin
            nxt_st.rdata = {9'h000, st_ff.pxcmd, next_ptr, `PCIX_CAP_ID}; // R11 R12
         end else if (hit(cfg_req_i.addr, `CFG_PCIX_STS_OFF)) begin
            nxt_st.rdata = pcix_status; // R11
         end else begin
            nxt_st.rdata = 32'h0000_0000;
         end
      end
      if (cfg_req_i.wr) begin
         if (hit(cfg_req_i.addr, `CFG_CMD_STS_OFF)) begin
            if (cfg_req_i.be[0]) begin
               nxt_st.cmd[7:0] = cfg_req_i.wdata[7:0]; // R01
            end
            if (cfg_req_i.be[1]) begin
               nxt_st.cmd[9:8] = cfg_req_i.wdata[9:8]; // R01
               nxt_st.cmd.int_disable = INT_DISABLE_IMPL & cfg_req_i.wdata[`CMD_INT_DIS]; // R03
            end
         end else if (hit(cfg_req_i.addr, `CFG_PCIX_CAP_OFF)) begin
            // writable in either bus mode; bytes 0 and 1 are read-only
            if (cfg_req_i.be[2]) begin
               nxt_st.pxcmd = cfg_req_i.wdata[22:16]; // R10
            end
         end else if (hit(cfg_req_i.addr, `CFG_PCIX_STS_OFF)) begin
            if (cfg_req_i.be[2] && cfg_req_i.wdata[`PCIX_STS_SCD] && !split_discard_i) begin
               nxt_st.scd = 1'b0;
            end
         end
      end
      nxt_st.pxctl = pcix_mode_i ? st_ff.pxcmd : '0; // R10
      nxt_st.split_ok = st_ff.cmd.master_en | pcix_mode_i; // R02
      nxt_st.inta_oe = int_pending_i & ~st_ff.cmd.int_disable; // R04
      nxt_st.link_int = int_pending_i & ~st_ff.cmd.int_disable; // R04
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         st_ff <= RESET_ST; // R01
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign cfg_rdata_o = st_ff.rdata;
   assign cfg_rvalid_o = st_ff.rvalid;
   assign cmd_o = st_ff.cmd;
   assign pcix_ctl_o = st_ff.pxctl;
   assign split_ok_o = st_ff.split_ok;
   assign inta_oe_o = st_ff.inta_oe;
   assign link_int_o = st_ff.link_int;
   assign serr_oe_o = st_ff.serr_oe;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   logic rd_cs;
   logic rd_cap;
   assign rd_cs = cfg_req_i.rd && hit(cfg_req_i.addr, `CFG_CMD_STS_OFF);
   assign rd_cap = cfg_req_i.rd && hit(cfg_req_i.addr, `CFG_PCIX_CAP_OFF);
   logic rd_pxs;
   logic wr_cs;
   logic wr_cap;
   logic wr_pxs;
   logic rd_none;
   assign rd_pxs = cfg_req_i.rd && hit(cfg_req_i.addr, `CFG_PCIX_STS_OFF);
   assign wr_cs = cfg_req_i.wr && hit(cfg_req_i.addr, `CFG_CMD_STS_OFF);
   assign wr_cap = cfg_req_i.wr && hit(cfg_req_i.addr, `CFG_PCIX_CAP_OFF);
   assign wr_pxs = cfg_req_i.wr && hit(cfg_req_i.addr, `CFG_PCIX_STS_OFF);
   assign rd_none = cfg_req_i.rd && !rd_cs && !rd_cap && !rd_pxs;

   property p_cmd_reset;
      disable iff (1'b0) srst_i |=> (cmd_o == '0) && !inta_oe_o && !serr_oe_o;
   endproperty
   a_cmd_reset: assert property (p_cmd_reset) else $error("command not zero after reset"); // R01

   property p_split_ok;
      (pcix_mode_i && !cmd_o.master_en) ##1 !srst_i |-> split_ok_o;
   endproperty
   a_split_ok: assert property (p_split_ok) else $error("split completion blocked in pci-x"); // R02

   property p_int_gate;
      int_pending_i |=> (inta_oe_o == !$past(cmd_o.int_disable)) && (link_int_o == inta_oe_o);
   endproperty
   a_int_gate: assert property (p_int_gate) else $error("interrupt gating wrong"); // R04

   property p_sts_fixed;
      rd_cs |=> cfg_rvalid_o && cfg_rdata_o[20] && cfg_rdata_o[21] && !cfg_rdata_o[22]
               && (cfg_rdata_o[26:25] == `STS_DEVSEL_MEDIUM) && (cfg_rdata_o[18:16] == 3'h0);
   endproperty
   a_sts_fixed: assert property (p_sts_fixed) else $error("fixed status bits wrong"); // R05 R06 R08

   property p_fb2b_pcix;
      (rd_cs && pcix_mode_i) |=> !cfg_rdata_o[16 + `STS_FB2B];
   endproperty
   a_fb2b_pcix: assert property (p_fb2b_pcix) else $error("fast b2b capable set in pci-x"); // R07

   property p_reserved;
      rd_cs |=> (cfg_rdata_o[15:11] == 5'h00) && (INT_DISABLE_IMPL || !cfg_rdata_o[10]);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved command bits not zero"); // R16 R03

   property p_cap_hdr;
      rd_cap |=> (cfg_rdata_o[7:0] == `PCIX_CAP_ID)
                 && (cfg_rdata_o[15:8] == ((!$past(pcix_mode_i) && $past(msi_disabled_i))
                                            ? `PCIX_NEXT_NONE : `PCIX_NEXT_PTR));
   endproperty
   a_cap_hdr: assert property (p_cap_hdr) else $error("capability header wrong"); // R11 R12 R13

   property p_pcix_gate;
      !pcix_mode_i |=> (pcix_ctl_o == '0);
   endproperty
   a_pcix_gate: assert property (p_pcix_gate) else $error("pci-x control active in conventional"); // R10

   property p_serr_parity;
      ($rose(flags.data_parity) && !recovery_on && cmd_o.serr_en) |=> serr_oe_o ##1 flags.sig_serr;
   endproperty
   a_serr_parity: assert property (p_serr_parity) else $error("parity did not raise serr"); // R14

   property p_cmd_low_wr;
      (wr_cs && cfg_req_i.be[0]) |=> (cmd_o[7:0] == $past(cfg_req_i.wdata[7:0]));
   endproperty
   a_cmd_low_wr: assert property (p_cmd_low_wr) else $error("command low byte not written"); // R01

   property p_int_dis_wr;
      (wr_cs && cfg_req_i.be[1]) |=> (cmd_o.int_disable
         == (INT_DISABLE_IMPL && $past(cfg_req_i.wdata[`CMD_INT_DIS])));
   endproperty
   a_int_dis_wr: assert property (p_int_dis_wr) else $error("interrupt disable write wrong"); // R03

   property p_cmd_hold;
      !(wr_cs && (cfg_req_i.be[0] || cfg_req_i.be[1])) |=> $stable(cmd_o);
   endproperty
   a_cmd_hold: assert property (p_cmd_hold) else $error("command changed without a write"); // R16

   property p_int_status;
      rd_cs |=> (cfg_rdata_o[16 + `STS_INT] == $past(int_pending_i));
   endproperty
   a_int_status: assert property (p_int_status) else $error("pending bit not reported"); // R04

   property p_err_status;
      rd_cs |=> (cfg_rdata_o[31:27] == $past(flags[5:1]))
                && (cfg_rdata_o[16 + `STS_DPR] == $past(flags.data_parity));
   endproperty
   a_err_status: assert property (p_err_status) else $error("error flags misplaced"); // R09

   property p_pxcmd_wr;
      (wr_cap && cfg_req_i.be[2]) |=> (st_ff.pxcmd == $past(cfg_req_i.wdata[22:16]));
   endproperty
   a_pxcmd_wr: assert property (p_pxcmd_wr) else $error("pci-x command not written"); // R10

   property p_pcix_ctl;
      pcix_mode_i |=> (pcix_ctl_o == $past(st_ff.pxcmd));
   endproperty
   a_pcix_ctl: assert property (p_pcix_ctl) else $error("pci-x control not applied"); // R10

   property p_scd_set;
      split_discard_i |=> st_ff.scd;
   endproperty
   a_scd_set: assert property (p_scd_set) else $error("discarded completion not flagged"); // R15

   property p_scd_clr;
      (wr_pxs && cfg_req_i.be[2] && cfg_req_i.wdata[`PCIX_STS_SCD] && !split_discard_i)
         |=> !st_ff.scd;
   endproperty
   a_scd_clr: assert property (p_scd_clr) else $error("discard flag not cleared"); // R15

   property p_split_master;
      cmd_o.master_en |=> split_ok_o;
   endproperty
   a_split_master: assert property (p_split_master) else $error("split blocked with mastering"); // R02

   property p_split_off;
      (!cmd_o.master_en && !pcix_mode_i) |=> !split_ok_o;
   endproperty
   a_split_off: assert property (p_split_off) else $error("split allowed without mastering"); // R02

   property p_serr_gate;
      !cmd_o.serr_en |=> !serr_oe_o;
   endproperty
   a_serr_gate: assert property (p_serr_gate) else $error("serr driven while disabled"); // R14

   property p_serr_recover;
      (recovery_on && !serr_req_i) |=> !serr_oe_o;
   endproperty
   a_serr_recover: assert property (p_serr_recover) else $error("serr driven in recovery"); // R14

   property p_rvalid_pulse;
      !cfg_req_i.rd |=> !cfg_rvalid_o;
   endproperty
   a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid without a read"); // R11

   property p_rdata_hold;
      !cfg_req_i.rd |=> $stable(cfg_rdata_o);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a read"); // R11

   property p_unmapped;
      rd_none |=> (cfg_rdata_o == 32'h0000_0000);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // R16

   property p_pxs_fixed;
      rd_pxs |=> (cfg_rdata_o[31:19] == 13'h0000)
                 && (cfg_rdata_o[15:8] == `PCIX_BUS_NUM_RST)
                 && (cfg_rdata_o[7:3] == `PCIX_DEV_NUM_RST)
                 && (cfg_rdata_o[2:0] == `PCIX_FUNC_NUM_RST);
   endproperty
   a_pxs_fixed: assert property (p_pxs_fixed) else $error("pci-x status fixed fields wrong"); // R11

   c_int: cover property (int_pending_i && !cmd_o.int_disable ##1 inta_oe_o);
   c_serr: cover property (serr_oe_o);
   c_cap_rd: cover property (rd_cap ##1 cfg_rvalid_o);
   c_cmd_wr: cover property (cfg_req_i.wr && cfg_req_i.be[0] ##1 cmd_o.master_en);
   c_scd_clr: cover property (wr_pxs ##1 !st_ff.scd);

endmodule

// ===== tb/cfg_host_model.sv
module cfg_host_model (
   input wire logic ref_clk_i,
   input wire logic [31:0] cfg_rdata_i,
   input wire logic cfg_rvalid_i,
   output pci_cfg_pkg::cfg_req_t cfg_req_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial cfg_req_o = '0;
   // idle lanes carry the inverse of the last request so stale values never look valid
   task automatic drop();
      @(negedge ref_clk_i);
      cfg_req_o = ~cfg_req_o & {2'b00, {44{1'b1}}};
   endtask
   // writing one clears a flag, so callers set only the bits they mean to clear
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(negedge ref_clk_i);
      cfg_req_o = {1'b1, 1'b0, a, be, d};
      drop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(negedge ref_clk_i);
      cfg_req_o = {1'b0, 1'b1, a, 4'hf, 32'h0000_0000};
      drop();
      n = 0;
      while (cfg_rvalid_i !== 1'b1 && n < 4) begin
         @(negedge ref_clk_i);
         n++;
      end
      d = (cfg_rvalid_i === 1'b1) ? cfg_rdata_i : 32'hxxxx_xxxx;
   endtask
endmodule

// ===== tb/test_pci_config_cmd_status_regs.sv
module test_pci_config_cmd_status_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 0;
   logic srst_i = 1;
   logic pcix_mode_i = 0;
   logic msi_disabled_i = 0;
   logic int_pending_i = 0;
   logic serr_req_i = 0;
   logic split_discard_i = 0;
   pci_cfg_pkg::err_events_t err_evt_i = '0;
   pci_cfg_pkg::cfg_req_t cfg_req;
   pci_cfg_pkg::cmd_bits_t cmd;
   pci_cfg_pkg::pcix_cmd_t pxctl;
   logic [31:0] cfg_rdata;
   logic cfg_rvalid, split_ok, inta_oe, link_int, serr_oe, seen;
   int error_cnt = 0;
   int checks = 0;
   int cycles = 0;

   always #5 ref_clk_i = ~ref_clk_i;

   cfg_host_model u_host (
      .ref_clk_i(ref_clk_i),
      .cfg_rdata_i(cfg_rdata),
      .cfg_rvalid_i(cfg_rvalid),
      .cfg_req_o(cfg_req)
   );

   pci_config_cmd_status_regs u_dut (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .cfg_req_i(cfg_req),
      .pcix_mode_i(pcix_mode_i),
      .msi_disabled_i(msi_disabled_i),
      .int_pending_i(int_pending_i),
      .err_evt_i(err_evt_i),
      .serr_req_i(serr_req_i),
      .split_discard_i(split_discard_i),
      .cfg_rdata_o(cfg_rdata),
      .cfg_rvalid_o(cfg_rvalid),
      .cmd_o(cmd),
      .pcix_ctl_o(pxctl),
      .split_ok_o(split_ok),
      .inta_oe_o(inta_oe),
      .link_int_o(link_int),
      .serr_oe_o(serr_oe)
   );

   task automatic print_verdict();
      $display("mismatches %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      u_host.rd(a, d);
      chk(d, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask

   task automatic pulse_err(input pci_cfg_pkg::err_events_t e);
      @(negedge ref_clk_i);
      err_evt_i = e;
      @(negedge ref_clk_i);
      err_evt_i = '0;
   endtask

   // serr is a one-cycle pulse, so look at every cycle of the window
   task automatic watch_serr();
      seen = 0;
      repeat (6) begin
         @(negedge ref_clk_i);
         if (serr_oe === 1'b1)
            seen = 1;
      end
   endtask

   task automatic t_reset();
      chk(32'(cmd), 32'h0000_0000);
      rc(8'h04, 32'h0230_0000);
      rc(8'he4, 32'h0002_f007);
      rc(8'he8, 32'h0003_fff8);
      rc(8'h40, 32'h0000_0000);
   endtask

   task automatic t_cmd();
      u_host.wr(8'h04, 4'h3, 32'h0000_ffff);
      rc(8'h04, 32'h0230_07ff);
      chk(32'(cmd), 32'h0000_07ff);
      u_host.wr(8'h04, 4'hc, 32'hffff_0000);
      rc(8'h04, 32'h0230_07ff);
      u_host.wr(8'he4, 4'h3, 32'h0000_0000);
      rc(8'he4, 32'h0002_f007);
      u_host.wr(8'h04, 4'h3, 32'h0000_0000);
   endtask

   task automatic t_mode();
      cyc(2);
      chk(32'(split_ok), 32'h0000_0000);
      chk(32'(pxctl), 32'h0000_0000);
      pcix_mode_i = 1;
      msi_disabled_i = 1;
      cyc(3);
      chk(32'(split_ok), 32'h0000_0001);
      chk(32'(pxctl), 32'h0000_0002);
      rc(8'h04, 32'h0230_0000);
      rc(8'he4, 32'h0002_f007);
      pcix_mode_i = 0;
      cyc(3);
      chk(32'(pxctl), 32'h0000_0000);
      rc(8'he4, 32'h0002_0007);
      msi_disabled_i = 0;
   endtask

   task automatic t_int();
      int_pending_i = 1;
      cyc(2);
      chk({inta_oe, link_int}, 32'h0000_0003);
      rc(8'h04, 32'h0238_0000);
      u_host.wr(8'h04, 4'h2, 32'h0000_0400);
      cyc(2);
      chk({inta_oe, link_int}, 32'h0000_0000);
      rc(8'h04, 32'h0238_0400);
      int_pending_i = 0;
      u_host.wr(8'h04, 4'h3, 32'h0000_0000);
   endtask

   task automatic t_err();
      pulse_err('1);
      rc(8'h04, 32'hfb30_0000);
      u_host.wr(8'h04, 4'hc, 32'h0000_0000);
      rc(8'h04, 32'hfb30_0000);
      u_host.wr(8'h04, 4'h8, 32'h1000_0000);
      rc(8'h04, 32'heb30_0000);
      u_host.wr(8'h04, 4'h2, 32'h0100_0000);
      rc(8'h04, 32'heb30_0000);
      u_host.wr(8'h04, 4'h8, 32'h0100_0000);
      rc(8'h04, 32'hea30_0000);
      u_host.wr(8'h04, 4'h8, 32'hf800_0000);
      rc(8'h04, 32'h0230_0000);
   endtask

   task automatic t_serr();
      u_host.wr(8'h04, 4'h2, 32'h0000_0100);
      fork
         pulse_err(6'h01);
         watch_serr();
      join
      chk(32'(seen), 32'h0000_0001);
      rc(8'h04, 32'h4330_0100);
      u_host.wr(8'h04, 4'ha, 32'h4100_0100);
      pcix_mode_i = 1;
      u_host.wr(8'he4, 4'h4, 32'h0003_0000);
      cyc(2);
      chk(32'(pxctl), 32'h0000_0003);
      fork
         pulse_err(6'h01);
         watch_serr();
      join
      chk(32'(seen), 32'h0000_0000);
      fork
         begin
            @(negedge ref_clk_i);
            serr_req_i = 1;
            @(negedge ref_clk_i);
            serr_req_i = 0;
         end
         watch_serr();
      join
      chk(32'(seen), 32'h0000_0001);
   endtask

   task automatic t_split();
      @(negedge ref_clk_i);
      split_discard_i = 1;
      @(negedge ref_clk_i);
      split_discard_i = 0;
      rc(8'he8, 32'h0007_fff8);
      u_host.wr(8'he8, 4'h4, 32'h0004_0000);
      rc(8'he8, 32'h0003_fff8);
   endtask

   initial begin
      cyc(8);
      srst_i = 0;
      t_reset();
      t_cmd();
      t_mode();
      t_int();
      t_err();
      t_serr();
      t_split();
      print_verdict();
   end
endmodule
